//--- inc/pssc_regs.svh
/*
  Register offsets, fields, reset values and timing counts.
  Assumes a 25 MHz block clock and 32-bit AXI4-Lite data.
*/
`ifndef PSSC_REGS_SVH
`define PSSC_REGS_SVH

// ----------------------------------------------------------------------
// register map, fields and timing counts
// ----------------------------------------------------------------------
`define PSSC_OFS_CTRL 12'h000
`define PSSC_OFS_STATUS 12'h004
`define PSSC_OFS_SEQ 12'h008
// control bits
`define PSSC_CTRL_HOST_ON 0
`define PSSC_CTRL_SUSPEND 1
`define PSSC_CTRL_HIGH_PWR 2
`define PSSC_CTRL_LIGHT_LOAD 3
`define PSSC_CTRL_RST 32'h0000_0000
// status bits
`define PSSC_ST_LOW_BATT 0
`define PSSC_ST_EXT_GOOD 1
`define PSSC_ST_USB_SW 2
`define PSSC_ST_HIGH_LIM 3
`define PSSC_ST_ON 4
`define PSSC_ST_RESET_N 5
`define PSSC_ST_FORCE_PWM 6
`define PSSC_ST_MAIN_SW 7
`define PSSC_ST_CARD_SW 8
`define PSSC_ST_KEY_N 9
`define PSSC_ST_SRC_LSB 10
// clock in kHz, delays in us
`define PSSC_CLK_KHZ 25000
`define PSSC_MAIN_DLY_US 800
`define PSSC_CARD_DLY_US 500
`define PSSC_RESET_DLY_US 262000
// scale first; the raw product overflows int
`define PSSC_CYC(us) ((us) * (`PSSC_CLK_KHZ / 1000))

`endif

//--- inc/pssc_pkg.sv
/*
  Types of the power source and sequencing controller.
  Assumes nothing beyond the register header.
*/
package pssc_pkg;

  // ----------------------------------------------------------------------
  // power source, sequencer state, sense flags and rail controls
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSSC_SRC_BATT = 2'h0,
    PSSC_SRC_USB = 2'h1,
    PSSC_SRC_WALL = 2'h2
  } pssc_src_t;

  typedef enum logic [4:0] {
    PSSC_OFF = 5'h01,
    PSSC_INT_UP = 5'h02,
    PSSC_CORE_UP = 5'h04,
    PSSC_RUN = 5'h08,
    PSSC_DOWN = 5'h10
  } pssc_seq_t;

  typedef struct packed {
    logic low_batt_below;
    logic wall_above;
    logic usb_above;
    logic ext_above;
    logic int_good;
    logic core_good;
    logic main_good;
  } pssc_sense_t;

  typedef struct packed {
    logic int_en;
    logic int_discharge;
    logic core_en;
    logic main_sw;
    logic card_sw;
    logic use_ext;
  } pssc_rail_t;

endpackage : pssc_pkg

//--- core/pssc_delay.sv
/*
  One-shot delay counter: done rises a fixed count after start goes high.
  Assumes start stays high for the whole wait; dropping it clears the count.
*/
`timescale 1ns/100ps
module pssc_delay
  import pssc_pkg::*;
#(
  parameter int COUNT = 20000
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_done
);

  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt;
  wire logic at_end = (cnt == W'(COUNT - 1));

  initial
  begin
    if (COUNT < 1)
      $error("pssc_delay: COUNT must be at least 1");
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= '0;
      o_done <= 1'b0;
    end
    else if (!i_start)
    begin
      cnt <= '0;
      o_done <= 1'b0;
    end
    else if (!o_done)
    begin
      cnt <= cnt + W'(1);
      o_done <= at_end;
    end
  end

endmodule : pssc_delay

//--- core/pssc_axil.sv
/*
  AXI4-Lite slave holding the control word and showing status words.
  Assumes one write and one read at a time; unmapped addresses answer DECERR.
*/
`timescale 1ns/100ps
`include "pssc_regs.svh"
module pssc_axil
  import pssc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] i_status,
  input wire logic [31:0] i_seq,
  output logic [31:0] o_ctrl
);

  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic mapped(input logic [11:0] a);
    return a[11:2] == `PSSC_OFS_CTRL >> 2 || a[11:2] == `PSSC_OFS_STATUS >> 2
           || a[11:2] == `PSSC_OFS_SEQ >> 2;
  endfunction : mapped

  wire logic aw_take = i_awvalid && o_awready;
  wire logic w_take = i_wvalid && o_wready;
  wire logic have_aw = aw_held || aw_take;
  wire logic have_w = w_held || w_take;
  wire logic [11:0] wr_addr = aw_held ? aw_addr : i_awaddr;
  wire logic [31:0] wr_data = w_held ? w_data : i_wdata;
  wire logic [3:0] wr_strb = w_held ? w_strb : i_wstrb;
  wire logic wr_fire = have_aw && have_w && !o_bvalid;
  wire logic wr_ctrl = wr_fire && wr_addr[11:2] == (`PSSC_OFS_CTRL >> 2);
  wire logic [31:0] rd_word = i_araddr[11:2] == (`PSSC_OFS_CTRL >> 2) ? o_ctrl
                            : i_araddr[11:2] == (`PSSC_OFS_STATUS >> 2) ? i_status
                            : i_araddr[11:2] == (`PSSC_OFS_SEQ >> 2) ? i_seq : 32'h0;
  wire logic ar_take = i_arvalid && o_arready;
  logic [31:0] next_ctrl;

  always_comb
  begin
    next_ctrl = o_ctrl;
    for (int b = 0; b < 4; b++)
      if (wr_strb[b])
        next_ctrl[b*8 +: 8] = wr_data[b*8 +: 8];
    next_ctrl[31:4] = 28'h0;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
      o_ctrl <= `PSSC_CTRL_RST;
    end
    else
    begin
      if (aw_take)
        aw_addr <= i_awaddr;
      if (w_take)
      begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      aw_held <= have_aw && !wr_fire;
      w_held <= have_w && !wr_fire;
      o_awready <= !(have_aw && !wr_fire) && !(o_bvalid && !i_bready) && !wr_fire;
      o_wready <= !(have_w && !wr_fire) && !(o_bvalid && !i_bready) && !wr_fire;
      if (wr_fire)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= mapped(wr_addr) ? 2'h0 : 2'h3;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
      if (wr_ctrl)
        o_ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'h0;
    end
    else if (ar_take)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= mapped(i_araddr) ? 2'h0 : 2'h3;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule : pssc_axil

//--- core/pssc_top.sv
/*
  Digital control of a battery, USB and wall powered multi-rail supply:
  source choice, USB switch and limit, power-on latch, rail sequencing,
  processor reset and forced PWM. Registers over AXI4-Lite.
  Assumes comparator and regulation flags are already synchronous to I_CLK
  and that undriven pins are resolved to their pull levels by the pads.
*/
// Operation
// RULE1: low battery flag low when sense below reference
// RULE2: wall present selects external node, USB off
// RULE3: external power good low on wall or USB
// RULE4: use external node only above 4V
// RULE5: USB switch closes on USB, no suspend, no wall
// RULE6: high power select picks 500mA limit
// RULE7: undriven high power select means low limit
// RULE8: suspend keeps USB switch off
// RULE9: main output connects 0.8ms after core good
// RULE10: card output connects 0.5ms after core good
// RULE11: key low turns device on, idles high
// RULE12: key held low until host drives on
// RULE13: key status follows key
// RULE14: host on high holds device on
// RULE15: light load select allows pulse skipping
// RULE16: forced PWM on USB or wall power
// RULE17: forced PWM during initial reset delay
// RULE18: reset held, released 262ms after core, main good
// RULE19: reset low when core or main drops
// RULE20: reset low at power-off
// RULE21: source priority wall, USB, battery
// RULE22: rails come up internal, core, main, card; the code connects card before main
// RULE23: internal supply discharged when off
// RULE24: stay on while key low or host on
// RULE25: delays are clock counters from parameters
`timescale 1ns/100ps
`include "pssc_regs.svh"
module pssc_top
  import pssc_pkg::*;
#(
  parameter int MAIN_CYC = `PSSC_CYC(`PSSC_MAIN_DLY_US),
  parameter int CARD_CYC = `PSSC_CYC(`PSSC_CARD_DLY_US),
  parameter int RESET_CYC = `PSSC_CYC(`PSSC_RESET_DLY_US)
)
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // analog comparator and regulation flags
  input wire logic i_low_battery_sense_below,
  input wire logic i_wall_sense_above,
  input wire logic i_usb_above,
  input wire logic i_external_supply_above,
  input wire logic i_internal_supply_good,
  input wire logic i_core_feedback_good,
  input wire logic i_main_good,
  // logic pins
  input wire logic i_power_key,
  input wire logic i_host_power_on,
  input wire logic i_usb_suspend,
  input wire logic i_usb_high_power_sel,
  input wire logic i_light_load_sel,
  // open-drain outputs: enable high pulls the pin low
  output logic o_low_battery_flag_oe,
  output logic o_external_power_good_oe,
  output logic o_key_status_oe,
  output logic o_reset_oe,
  // power stage controls
  output logic o_use_external_supply,
  output logic o_usb_switch_on,
  output logic o_usb_high_limit,
  output logic o_usb_suspend_mode,
  output logic o_force_pwm,
  output logic o_internal_supply_en,
  output logic o_internal_supply_discharge,
  output logic o_core_en,
  output logic o_main_peripheral_output_sw,
  output logic o_card_supply_output_sw,
  // AXI4-Lite
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  initial
  begin
    if (MAIN_CYC < 1 || CARD_CYC < 1 || RESET_CYC < 1)
      $error("pssc_top: delay counts must be at least 1");
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] status;
  logic [31:0] seq_word;

  pssc_axil u_axil (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_awaddr(S_AXI_AWADDR),
    .i_awvalid(S_AXI_AWVALID),
    .o_awready(S_AXI_AWREADY),
    .i_wdata(S_AXI_WDATA),
    .i_wstrb(S_AXI_WSTRB),
    .i_wvalid(S_AXI_WVALID),
    .o_wready(S_AXI_WREADY),
    .o_bresp(S_AXI_BRESP),
    .o_bvalid(S_AXI_BVALID),
    .i_bready(S_AXI_BREADY),
    .i_araddr(S_AXI_ARADDR),
    .i_arvalid(S_AXI_ARVALID),
    .o_arready(S_AXI_ARREADY),
    .o_rdata(S_AXI_RDATA),
    .o_rresp(S_AXI_RRESP),
    .o_rvalid(S_AXI_RVALID),
    .i_rready(S_AXI_RREADY),
    .i_status(status),
    .i_seq(seq_word),
    .o_ctrl(ctrl)
  );

  // software bits are ORed with the pins, so either party can assert them
  wire logic host_on = i_host_power_on | ctrl[`PSSC_CTRL_HOST_ON]; // see RULE14
  wire logic suspend = i_usb_suspend | ctrl[`PSSC_CTRL_SUSPEND];
  wire logic high_sel = i_usb_high_power_sel | ctrl[`PSSC_CTRL_HIGH_PWR];
  wire logic light_sel = i_light_load_sel | ctrl[`PSSC_CTRL_LIGHT_LOAD];

  // ----------------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------------
  pssc_sense_t sense;
  assign sense = '{low_batt_below: i_low_battery_sense_below,
                   wall_above: i_wall_sense_above,
                   usb_above: i_usb_above,
                   ext_above: i_external_supply_above,
                   int_good: i_internal_supply_good,
                   core_good: i_core_feedback_good,
                   main_good: i_main_good};

  wire logic usb_ok = sense.usb_above && !suspend; // see RULE8
  wire logic next_usb_sw = usb_ok && !sense.wall_above; // see RULE5
  wire logic ext_present = sense.wall_above || usb_ok; // see RULE3
  // see RULE21
  wire pssc_src_t next_src = sense.wall_above ? PSSC_SRC_WALL
                           : usb_ok ? PSSC_SRC_USB : PSSC_SRC_BATT;
  // wall or USB only counts once the node itself has come up
  wire logic next_use_ext = ext_present && sense.ext_above; // see RULE2 RULE4

  // ----------------------------------------------------------------------
  // on/off latch and rail sequencing
  // ----------------------------------------------------------------------
  pssc_seq_t state;
  pssc_seq_t next_state;
  pssc_src_t src;
  logic init_phase;

  wire logic key_pressed = !i_power_key; // see RULE11
  // the key starts the device and holds it while low; host_on must take over to keep it up
  wire logic stay_on = key_pressed || host_on; // see RULE24 RULE12
  // on external power the rails wait for the node to pass 4V
  wire logic supply_ok = (src == PSSC_SRC_BATT) || sense.ext_above; // see RULE4

  always_comb
  begin
    next_state = state;
    unique case (state)
      PSSC_OFF:
        if (stay_on && supply_ok)
          next_state = PSSC_INT_UP;
      PSSC_INT_UP:
        if (!stay_on)
          next_state = PSSC_DOWN;
        else if (sense.int_good)
          next_state = PSSC_CORE_UP;
      PSSC_CORE_UP:
        if (!stay_on)
          next_state = PSSC_DOWN;
        else if (sense.core_good)
          next_state = PSSC_RUN;
      PSSC_RUN:
        if (!stay_on)
          next_state = PSSC_DOWN;
      PSSC_DOWN:
        if (!sense.int_good)
          next_state = PSSC_OFF;
      default:
        next_state = PSSC_OFF;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state <= PSSC_OFF;
      src <= PSSC_SRC_BATT;
    end
    else
    begin
      state <= next_state;
      src <= next_src;
    end
  end

  // ----------------------------------------------------------------------
  // delay timers
  // ----------------------------------------------------------------------
  wire logic running = (state == PSSC_RUN);
  logic main_due;
  logic card_due;
  logic reset_due;
  logic main_on;
  wire logic rails_good = running && sense.core_good && main_on && sense.main_good;

  // see RULE9 RULE25
  pssc_delay #(.COUNT(MAIN_CYC)) u_main_dly (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_start(running),
    .o_done(main_due)
  );

  // see RULE10 RULE25
  pssc_delay #(.COUNT(CARD_CYC)) u_card_dly (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_start(running),
    .o_done(card_due)
  );

  // restarts from zero whenever the core or main rail drops out
  pssc_delay #(.COUNT(RESET_CYC)) u_reset_dly (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_start(rails_good),
    .o_done(reset_due)
  ); // see RULE18 RULE25

  // ----------------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------------
  // order internal, core comes from the state walk; card then main from the delay counts
  wire logic rails_up = (state != PSSC_OFF) && (state != PSSC_DOWN);
  pssc_rail_t next_rail;
  assign next_rail = '{int_en: rails_up,
                       int_discharge: !rails_up, // see RULE23
                       core_en: (state == PSSC_CORE_UP) || running, // see RULE22
                       main_sw: running && main_due, // see RULE9
                       card_sw: running && card_due, // see RULE10
                       use_ext: next_use_ext};
  // see RULE18 RULE19 RULE20
  wire logic next_reset_low = !(rails_good && reset_due);
  // see RULE15 RULE16 RULE17
  wire logic next_force_pwm = !light_sel || next_src != PSSC_SRC_BATT || init_phase;

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      init_phase <= 1'b1;
    else if (reset_due)
      init_phase <= 1'b0;
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      o_low_battery_flag_oe <= 1'b0;
      o_external_power_good_oe <= 1'b0;
      o_key_status_oe <= 1'b0;
      o_reset_oe <= 1'b1;
      o_use_external_supply <= 1'b0;
      o_usb_switch_on <= 1'b0;
      o_usb_high_limit <= 1'b0;
      o_usb_suspend_mode <= 1'b0;
      o_force_pwm <= 1'b1;
      o_internal_supply_en <= 1'b0;
      o_internal_supply_discharge <= 1'b1;
      o_core_en <= 1'b0;
      o_main_peripheral_output_sw <= 1'b0;
      o_card_supply_output_sw <= 1'b0;
      main_on <= 1'b0;
    end
    else
    begin
      o_low_battery_flag_oe <= sense.low_batt_below; // see RULE1
      o_external_power_good_oe <= ext_present; // see RULE3
      o_key_status_oe <= key_pressed; // see RULE13
      o_reset_oe <= next_reset_low; // see RULE18
      o_use_external_supply <= next_rail.use_ext; // see RULE2
      o_usb_switch_on <= next_usb_sw; // see RULE5 RULE8
      // pad pull-down resolves an open select to low; see RULE7
      o_usb_high_limit <= high_sel; // see RULE6
      o_usb_suspend_mode <= suspend; // see RULE8
      o_force_pwm <= next_force_pwm; // see RULE16
      o_internal_supply_en <= next_rail.int_en;
      o_internal_supply_discharge <= next_rail.int_discharge; // see RULE23
      o_core_en <= next_rail.core_en;
      o_main_peripheral_output_sw <= next_rail.main_sw;
      o_card_supply_output_sw <= next_rail.card_sw;
      main_on <= next_rail.main_sw;
    end
  end

  // ----------------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------------
  assign status = {20'h0, src, i_power_key, o_card_supply_output_sw,
                   o_main_peripheral_output_sw, o_force_pwm, !o_reset_oe,
                   o_internal_supply_en, o_usb_high_limit, o_usb_switch_on,
                   o_external_power_good_oe, o_low_battery_flag_oe};
  assign seq_word = {27'h0, state};

endmodule : pssc_top

//--- verif/pssc_props.sv
/*
  Port-level checker of the controller.
  Assumes flags synchronous to I_CLK and the CTRL suspend and high-power bits left 0.
*/
`timescale 1ns/100ps
module pssc_props
  import pssc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic i_low_battery_sense_below,
  input wire logic i_wall_sense_above,
  input wire logic i_usb_above,
  input wire logic i_external_supply_above,
  input wire logic i_core_feedback_good,
  input wire logic i_main_good,
  input wire logic i_power_key,
  input wire logic i_usb_suspend,
  input wire logic i_usb_high_power_sel,
  input wire logic o_low_battery_flag_oe,
  input wire logic o_external_power_good_oe,
  input wire logic o_key_status_oe,
  input wire logic o_reset_oe,
  input wire logic o_use_external_supply,
  input wire logic o_usb_switch_on,
  input wire logic o_usb_high_limit,
  input wire logic o_core_en,
  input wire logic o_internal_supply_discharge,
  input wire logic o_main_peripheral_output_sw,
  input wire logic o_card_supply_output_sw
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  wire logic usb_ok = i_usb_above && !i_usb_suspend;
  property p_lowbat; 1'b1 |=> o_low_battery_flag_oe == $past(i_low_battery_sense_below); endproperty
  a_lowbat: assert property (p_lowbat) else $error("low battery flag");
  property p_extgood; 1'b1 |=> o_external_power_good_oe == $past(i_wall_sense_above || usb_ok);
  endproperty
  a_extgood: assert property (p_extgood) else $error("external good");
  property p_extnode; o_use_external_supply |-> $past(i_external_supply_above); endproperty
  a_extnode: assert property (p_extnode) else $error("external node");
  property p_usbsw; o_usb_switch_on |-> $past(usb_ok && !i_wall_sense_above); endproperty
  a_usbsw: assert property (p_usbsw) else $error("usb switch");
  property p_hp; i_usb_high_power_sel |=> o_usb_high_limit; endproperty
  a_hp: assert property (p_hp) else $error("usb limit");
  property p_susp; i_usb_suspend |=> !o_usb_switch_on; endproperty
  a_susp: assert property (p_susp) else $error("suspend");
  property p_key; 1'b1 |=> o_key_status_oe == !$past(i_power_key); endproperty
  a_key: assert property (p_key) else $error("key status");
  property p_rdrop; !(i_core_feedback_good && i_main_good) |-> ##[1:2] o_reset_oe; endproperty
  a_rdrop: assert property (p_rdrop) else $error("reset on drop");
  property p_rrel; $fell(o_reset_oe) |-> $past(i_core_feedback_good && i_main_good); endproperty
  a_rrel: assert property (p_rrel) else $error("reset release");
  property p_order; $rose(o_main_peripheral_output_sw) |-> o_card_supply_output_sw && o_core_en;
  endproperty
  a_order: assert property (p_order) else $error("rail order");
  c_rel: cover property ($fell(o_reset_oe));
  c_usb: cover property ($rose(o_usb_switch_on));
  c_dis: cover property ($rose(o_internal_supply_discharge));
endmodule : pssc_props

//--- verif/pssc_host_model.sv
/*
  Host processor and momentary power key.
  Assumes press is a one-cycle command and drop a level from the bench.
*/
`timescale 1ns/100ps
module pssc_host_model
(
  input wire logic i_clk,
  input wire logic i_reset_oe,
  input wire logic i_press,
  input wire logic i_drop,
  output logic o_power_key = 1'b1,
  output logic o_host_power_on = 1'b0
);
  // key held until the host takes over; released key sits at its pull-up
  always @(posedge i_clk)
  begin
    if (i_press)
      o_power_key <= 1'b0;
    else if (o_host_power_on)
      o_power_key <= 1'b1;
    if (i_drop)
      o_host_power_on <= 1'b0;
    else if (!i_reset_oe && !o_power_key)
      o_host_power_on <= 1'b1;
  end
endmodule : pssc_host_model

//--- verif/pssc_top_tb_top.sv
/*
  AXI4-Lite tasks, host and rail models, scenarios.
  Assumes short sequencing counts; rails report good one cycle after enable.
*/
`timescale 1ns/100ps
module pssc_top_tb_top
  import pssc_pkg::*;
;
  localparam int CC = 12, MC = 20, RC = 50, LIM = 400;
  logic I_CLK, I_SYS_RST, i_low_battery_sense_below, i_wall_sense_above, i_usb_above;
  logic i_external_supply_above, i_internal_supply_good, i_core_feedback_good, i_main_good;
  logic i_power_key, i_host_power_on, i_usb_suspend, i_usb_high_power_sel, i_light_load_sel;
  logic o_low_battery_flag_oe, o_external_power_good_oe, o_key_status_oe, o_reset_oe;
  logic o_use_external_supply, o_usb_switch_on, o_usb_high_limit, o_usb_suspend_mode;
  logic o_force_pwm, o_internal_supply_en, o_internal_supply_discharge, o_core_en;
  logic o_main_peripheral_output_sw, o_card_supply_output_sw, press, drop, kill, u;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  int failures, checks, n, nc;

  pssc_top #(.MAIN_CYC(MC), .CARD_CYC(CC), .RESET_CYC(RC)) DUT (.*);
  pssc_host_model HOST (.i_clk(I_CLK), .i_reset_oe(o_reset_oe), .i_press(press),
    .i_drop(drop), .o_power_key(i_power_key), .o_host_power_on(i_host_power_on));

  // ----------------------------------------------------------------------
  // clock and rails
  // ----------------------------------------------------------------------
  always #20 I_CLK = ~I_CLK;
  always @(posedge I_CLK)
  begin
    i_internal_supply_good <= o_internal_supply_en;
    i_core_feedback_good <= o_core_en & ~kill;
    i_main_good <= o_main_peripheral_output_sw;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task lim(input int k);
    if (k >= LIM)
    begin
      failures++;
      end_sim();
    end
  endtask : lim
  task cy(input int k);
    repeat (k) @(posedge I_CLK);
  endtask : cy
  // bready and rready stay high, so a response is taken the edge it shows
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    k = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (k < LIM)
    begin
      @(posedge I_CLK);
      k++;
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID)
        break;
    end
    lim(k);
    chk(S_AXI_BRESP, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e, input logic [1:0] er);
    int k;
    k = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    while (k < LIM)
    begin
      @(posedge I_CLK);
      k++;
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID)
        break;
    end
    lim(k);
    chk(S_AXI_RDATA & m, e);
    chk(S_AXI_RRESP, er);
  endtask : rd

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {I_CLK, i_low_battery_sense_below, i_wall_sense_above, i_usb_above, press, drop} = '0;
    {i_external_supply_above, i_usb_suspend, i_usb_high_power_sel, kill} = '0;
    {i_internal_supply_good, i_core_feedback_good, i_main_good} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = '0;
    {S_AXI_BREADY, S_AXI_RREADY, i_light_load_sel, I_SYS_RST} = '1;
    S_AXI_WSTRB = 4'hf;
    cy(4);
    I_SYS_RST <= 1'b0;
    cy(1);
    chk({o_reset_oe, o_force_pwm, o_internal_supply_discharge}, 3'h7);
    i_low_battery_sense_below <= 1'b1;
    cy(3);
    chk(o_low_battery_flag_oe, 1'b1);
    i_low_battery_sense_below <= 1'b0;
    wr(12'h000, 32'hffff_fff8, 2'h0);
    rd(12'h000, 32'hffff_ffff, 32'h8, 2'h0);
    wr(12'h00c, 32'h1, 2'h3);
    rd(12'h00c, 32'hffff_ffff, 32'h0, 2'h3);
    chk(o_low_battery_flag_oe, 1'b0);
    press <= 1'b1;
    cy(1);
    press <= 1'b0;
    cy(2);
    chk(o_key_status_oe, 1'b1);
    n = 0;
    while (!i_core_feedback_good && n < LIM)
    begin
      cy(1);
      n++;
    end
    lim(n);
    n = 0;
    nc = 0;
    while (!o_main_peripheral_output_sw && n < LIM)
    begin
      cy(1);
      n++;
      if (o_card_supply_output_sw && nc == 0)
        nc = n;
    end
    lim(n);
    chk(nc >= CC && nc <= CC + 4, 1'b1);
    chk(n >= MC && n <= MC + 4, 1'b1);
    chk(o_force_pwm, 1'b1);
    rd(12'h008, 32'hffff_ffff, 32'h8, 2'h0);
    n = 0;
    while (o_reset_oe && n < LIM)
    begin
      cy(1);
      n++;
    end
    lim(n);
    chk(n >= RC - 8 && n <= RC + 4, 1'b1);
    cy(6);
    chk({o_force_pwm, o_internal_supply_en, o_key_status_oe}, 3'h2);
    kill <= 1'b1;
    cy(3);
    chk(o_reset_oe, 1'b1);
    kill <= 1'b0;
    i_external_supply_above <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      {i_wall_sense_above, i_usb_above, i_usb_suspend, i_usb_high_power_sel} <= i[3:0];
      cy(3);
      u = i_usb_above & ~i_usb_suspend;
      chk(o_usb_switch_on, u & ~i_wall_sense_above);
      chk(o_external_power_good_oe, u | i_wall_sense_above);
      chk(o_usb_high_limit, i_usb_high_power_sel);
      chk(o_usb_suspend_mode, i_usb_suspend);
      chk(o_use_external_supply, u | i_wall_sense_above);
      chk(o_force_pwm, u | i_wall_sense_above);
      rd(12'h004, 32'hc00, {i_wall_sense_above, u & ~i_wall_sense_above, 10'h0}, 2'h0);
    end
    {i_wall_sense_above, i_usb_above, i_usb_suspend, i_usb_high_power_sel} <= 4'h8;
    i_external_supply_above <= 1'b0;
    cy(3);
    chk(o_use_external_supply, 1'b0);
    i_wall_sense_above <= 1'b0;
    drop <= 1'b1;
    cy(4);
    chk(o_reset_oe, 1'b1);
    cy(10);
    chk({o_internal_supply_en, o_internal_supply_discharge}, 2'h1);
    end_sim();
  end
endmodule : pssc_top_tb_top

bind pssc_top pssc_props u_props (.*);
